// File: rtl/tss_regs.svh
// tss_regs.svh: constants of the slot switch (sizes, positions, masks)
// assumes: included by bare name from every rtl file that needs it
`ifndef TSS_REGS_SVH
`define TSS_REGS_SVH

// ----------------------------------------------------------------------------
// frame and storage sizes
// ----------------------------------------------------------------------------
`define TSS_SLOTS      128
`define TSS_SLOT_W     7
`define TSS_MON_DEPTH  16
`define TSS_MON_AW     4
`define TSS_OUT_DEPTH  2
`define TSS_OUT_AW     1

// ----------------------------------------------------------------------------
// data values and bit masks
// ----------------------------------------------------------------------------
`define TSS_IDLE       8'hff
`define TSS_MASK8      8'hff
`define TSS_MASK6      8'hfc
`define TSS_MASK4      8'hf0
`define TSS_SUB4       8'h0f
`define TSS_SUB2       8'h03
`define TSS_DCH_MASK   8'hc0
`define TSS_DCH_LSB    6

// ----------------------------------------------------------------------------
// field values
// ----------------------------------------------------------------------------
`define TSS_CFI_POS4   3'h4
`define TSS_CFI_POS2   3'h6
`define TSS_POS_EVEN   2'h0
`define TSS_POS_ODD    2'h1
`define TSS_WID8       2'h0
`define TSS_WID6       2'h1
`define TSS_WID4       2'h2
`define TSS_DIR_DN     1'b1
`define TSS_DIR_UP     1'b0
`define TSS_KIND_ONE   2'h0
`define TSS_KIND_PAIR  2'h1
`define TSS_KIND_LOOP  2'h2
`define TSS_KIND_CLEAR 2'h3

`endif

// File: rtl/tss_pkg.sv
// tss_pkg: types shared by both ends of the slot switch
// assumes: nothing beyond the compiler
package tss_pkg;

  typedef enum logic [3:0] {
    TSS_CODE_FREE   = 4'h0,
    TSS_CODE_SW8    = 4'h1,
    TSS_CODE_SW4    = 4'h2,
    TSS_CODE_SW2    = 4'h3,
    TSS_CODE_PROC   = 4'h4,
    TSS_CODE_PRE    = 4'h7,
    TSS_CODE_PRE_DC = 4'h8,
    TSS_CODE_PRE_CC = 4'ha
  } tss_code_type;

  typedef struct packed {
    tss_code_type code;
    logic [1:0]   pos;
    logic [1:0]   width;
    logic [7:0]   data;
  } tss_entry_type;

  typedef enum logic [1:0] {
    TSS_ST_IDLE   = 2'h0,
    TSS_ST_SECOND = 2'h1
  } tss_state_type;

endpackage

// File: rtl/tss_if.sv
// tss_if: link between the map-programming host end and the switching end
// assumes: both ends run on the same sys_clk
`timescale 1ns/1ps
interface tss_if;
  logic       map_wr;
  logic       map_dir;
  logic [6:0] map_address;
  logic [3:0] map_command;
  logic [7:0] map_data;
  logic [1:0] map_pos;
  logic [1:0] map_width;
  logic       map_clear;
  logic       rd_req;
  logic [6:0] rd_address;
  logic       rd_valid;
  logic [7:0] rd_data;
  logic       sin_valid;
  logic       sin_ready;
  logic       sin_frame;
  logic [7:0] sin_pcm;
  logic [7:0] sin_cfi;
  logic       sout_valid;
  logic       sout_ready;
  logic [7:0] sout_cfi;
  logic [7:0] sout_pcm;

  modport device (
    input  map_wr, map_dir, map_address, map_command, map_data, map_pos, map_width, map_clear,
    input  rd_req, rd_address, sin_valid, sin_frame, sin_pcm, sin_cfi, sout_ready,
    output rd_valid, rd_data, sin_ready, sout_valid, sout_cfi, sout_pcm
  );

  modport host (
    output map_wr, map_dir, map_address, map_command, map_data, map_pos, map_width, map_clear,
    output rd_req, rd_address, sin_valid, sin_frame, sin_pcm, sin_cfi, sout_ready,
    input  rd_valid, rd_data, sin_ready, sout_valid, sout_cfi, sout_pcm
  );
endinterface

// File: rtl/tss_fifo.sv
// tss_fifo: small first-in first-out store with valid/ready on both sides
// assumes: DEPTH equals two to the power AW
`timescale 1ns/1ps
module tss_fifo #(
  parameter int DW    = 8,
  parameter int DEPTH = 2,
  parameter int AW    = 1
) (
  input  wire logic          sys_clk,
  input  wire logic          sys_rst,
  input  wire logic          ce,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [DW-1:0] in_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [DW-1:0]      out_data
);
  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  wire           push;
  wire           pop;

  assign in_ready  = ce && (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = ce && (cnt_reg != '0);
  assign out_data  = mem[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (ce && push) begin
      mem[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else if (ce) begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule // tss_fifo

// File: rtl/tss_switch.sv
// tss_switch: slot interchange between highway and subscriber-side slots
// assumes: one slot pair per accepted link beat, sin_frame marks slot 0
`timescale 1ns/1ps
`include "tss_regs.svh"

// Summary of operation
// - 128 slots switched in each direction
// - map written once, data moved every frame
// - software reserves spare slots for loopbacks
// - switching on 8-bit slots, 4/2-bit sub-slots
// - up to four sub-slots per highway slot
// - highway sub-slot position freely chosen
// - subscriber sub-slot position fixed per port
// - processor downstream value resent every frame
// - processor upstream byte readable, no interrupt
// - pre-processed pairs start on even slot
// - even pre-processed slot uses 16-byte FIFO
// - odd slot sends static 4/6/8 bits
// - odd upstream change raises an interrupt
// - map reset marks every entry unassigned
// - pairs may be reprogrammed while running
// - arbiter routes D-channel bits to HDLC
// - pair written with fields 00/01, code 0111, 1000 or 1010
// - upstream and downstream maps are separate
module tss_switch (
  input  wire logic   sys_clk,
  input  wire logic   sys_rst,
  input  wire logic   ce,
  tss_if.device       link,
  input  wire logic   dch_enable,
  input  wire logic [1:0] hdlc_dn_bits,
  output logic        hdlc_up_valid,
  output logic [1:0]  hdlc_up_bits,
  output logic        change_irq,
  input  wire logic   mon_tx_valid,
  output logic        mon_tx_ready,
  input  wire logic [7:0] mon_tx_data,
  output logic        mon_rx_valid,
  input  wire logic   mon_rx_ready,
  output logic [7:0]  mon_rx_data
);
  // --------------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------------
  tss_pkg::tss_entry_type dn_map [`TSS_SLOTS];
  tss_pkg::tss_entry_type up_map [`TSS_SLOTS];
  logic [7:0]             dn_mem [`TSS_SLOTS];
  logic [7:0]             up_mem [`TSS_SLOTS];
  logic [7:0]             cap_mem [`TSS_SLOTS];
  logic [`TSS_SLOT_W-1:0] slot_reg;
  logic                   rd_valid_reg;
  logic [7:0]             rd_data_reg;
  logic                   change_reg;
  logic                   hdlc_valid_reg;
  logic [1:0]             hdlc_bits_reg;

  // --------------------------------------------------------------------------
  // decoding helpers
  // --------------------------------------------------------------------------
  function automatic logic [7:0] sub_mask(input tss_pkg::tss_code_type c);
    logic [7:0] m;
    m = `TSS_MASK8;
    if (c == tss_pkg::TSS_CODE_SW4) begin
      m = `TSS_SUB4;
    end else if (c == tss_pkg::TSS_CODE_SW2) begin
      m = `TSS_SUB2;
    end
    return m;
  endfunction

  function automatic logic [2:0] cfi_pos(input tss_pkg::tss_code_type c);
    logic [2:0] p;
    p = 3'h0;
    if (c == tss_pkg::TSS_CODE_SW4) begin
      p = `TSS_CFI_POS4;
    end else if (c == tss_pkg::TSS_CODE_SW2) begin
      p = `TSS_CFI_POS2;
    end
    return p;
  endfunction

  function automatic logic [7:0] odd_mask(input logic [1:0] w);
    logic [7:0] m;
    m = `TSS_MASK8;
    if (w == `TSS_WID6) begin
      m = `TSS_MASK6;
    end else if (w == `TSS_WID4) begin
      m = `TSS_MASK4;
    end
    return m;
  endfunction

  function automatic logic is_sw(input tss_pkg::tss_code_type c);
    return c == tss_pkg::TSS_CODE_SW8 || c == tss_pkg::TSS_CODE_SW4 || c == tss_pkg::TSS_CODE_SW2;
  endfunction

  function automatic logic is_pre(input tss_pkg::tss_code_type c);
    return c == tss_pkg::TSS_CODE_PRE || c == tss_pkg::TSS_CODE_PRE_DC || c == tss_pkg::TSS_CODE_PRE_CC;
  endfunction

  // --------------------------------------------------------------------------
  // slot timing
  // --------------------------------------------------------------------------
  wire                     out_in_ready;
  wire                     beat = link.sin_valid && out_in_ready;
  wire [`TSS_SLOT_W-1:0]   cur  = link.sin_frame ? '0 : slot_reg;
  tss_pkg::tss_entry_type  de;
  tss_pkg::tss_entry_type  ue;
  assign de = dn_map[cur];
  assign ue = up_map[cur];

  // --------------------------------------------------------------------------
  // downstream: highway byte toward the subscriber side
  // --------------------------------------------------------------------------
  wire [2:0] dn_psh   = {de.pos, 1'b0};
  wire [7:0] dn_wm    = sub_mask(de.code);
  wire [7:0] dn_src   = dn_mem[de.data[`TSS_SLOT_W-1:0]];
  wire [7:0] dn_al    = (dn_src >> dn_psh) & dn_wm;
  wire [7:0] dn_sw    = (dn_al << cfi_pos(de.code)) | (`TSS_IDLE & ~(dn_wm << cfi_pos(de.code)));
  wire       dn_even  = is_pre(de.code) && de.pos == `TSS_POS_EVEN;
  wire       dn_odd   = is_pre(de.code) && de.pos == `TSS_POS_ODD;
  wire       dn_dch   = dch_enable && de.code != tss_pkg::TSS_CODE_PRE;
  wire [7:0] odd_st   = (de.data & odd_mask(de.width)) | (`TSS_IDLE & ~odd_mask(de.width));
  wire [7:0] odd_dn   = dn_dch ? ((odd_st & ~`TSS_DCH_MASK) | {hdlc_dn_bits, 6'h00}) : odd_st;
  wire       mtx_vld;
  wire [7:0] mtx_dat;
  wire       mtx_pop  = beat && dn_even;
  wire [7:0] dn_mon   = mtx_vld ? mtx_dat : `TSS_IDLE;
  wire [7:0] cfi_out  = is_sw(de.code) ? dn_sw :
                        de.code == tss_pkg::TSS_CODE_PROC ? de.data :
                        dn_even ? dn_mon :
                        dn_odd ? odd_dn : `TSS_IDLE;

  // --------------------------------------------------------------------------
  // upstream: subscriber byte toward the highway
  // --------------------------------------------------------------------------
  wire [2:0]             up_psh  = {ue.pos, 1'b0};
  wire [7:0]             up_wm   = sub_mask(ue.code);
  wire [7:0]             up_al   = (link.sin_cfi >> cfi_pos(ue.code)) & up_wm;
  wire [7:0]             up_bm   = up_wm << up_psh;
  wire [`TSS_SLOT_W-1:0] up_dst  = ue.data[`TSS_SLOT_W-1:0];
  wire [7:0]             up_new  = (up_mem[up_dst] & ~up_bm) | ((up_al << up_psh) & up_bm);
  wire                   up_even = is_pre(ue.code) && ue.pos == `TSS_POS_EVEN;
  wire                   up_odd  = is_pre(ue.code) && ue.pos == `TSS_POS_ODD;
  wire                   up_cap  = up_odd || ue.code == tss_pkg::TSS_CODE_PROC;
  wire                   up_chg  = up_odd && (((link.sin_cfi ^ cap_mem[cur]) & odd_mask(ue.width)) != 8'h00);
  wire                   up_dch  = up_odd && dch_enable && ue.code != tss_pkg::TSS_CODE_PRE;
  wire                   mrx_push = beat && up_even;

  // --------------------------------------------------------------------------
  // buffers
  // --------------------------------------------------------------------------
  tss_fifo #(.DW(16), .DEPTH(`TSS_OUT_DEPTH), .AW(`TSS_OUT_AW)) u_out (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .in_valid  (link.sin_valid),
    .in_ready  (out_in_ready),
    .in_data   ({cfi_out, up_mem[cur]}),
    .out_valid (link.sout_valid),
    .out_ready (link.sout_ready),
    .out_data  ({link.sout_cfi, link.sout_pcm})
  );

  tss_fifo #(.DW(8), .DEPTH(`TSS_MON_DEPTH), .AW(`TSS_MON_AW)) u_mon_tx (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .in_valid  (mon_tx_valid),
    .in_ready  (mon_tx_ready),
    .in_data   (mon_tx_data),
    .out_valid (mtx_vld),
    .out_ready (mtx_pop),
    .out_data  (mtx_dat)
  );

  tss_fifo #(.DW(8), .DEPTH(`TSS_MON_DEPTH), .AW(`TSS_MON_AW)) u_mon_rx (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .in_valid  (mrx_push),
    .in_ready  (),
    .in_data   (link.sin_cfi),
    .out_valid (mon_rx_valid),
    .out_ready (mon_rx_ready),
    .out_data  (mon_rx_data)
  );

  // --------------------------------------------------------------------------
  // map store
  // --------------------------------------------------------------------------
  tss_pkg::tss_entry_type wr_entry;
  assign wr_entry = '{code: tss_pkg::tss_code_type'(link.map_command), pos: link.map_pos,
                      width: link.map_width, data: link.map_data};

  always_ff @(posedge sys_clk) begin
    if (sys_rst || (ce && link.map_clear)) begin
      for (int i = 0; i < `TSS_SLOTS; i++) begin
        dn_map[i] <= '0;
        up_map[i] <= '0;
      end
    end else if (ce && link.map_wr) begin
      if (link.map_dir == `TSS_DIR_DN) begin
        dn_map[link.map_address] <= wr_entry;
      end else begin
        up_map[link.map_address] <= wr_entry;
      end
    end
  end

  // --------------------------------------------------------------------------
  // slot data stores
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (ce && beat) begin
      dn_mem[cur] <= link.sin_pcm;
      if (is_sw(ue.code)) begin
        up_mem[up_dst] <= up_new;
      end
      if (up_cap) begin
        cap_mem[cur] <= link.sin_cfi;
      end
    end
  end

  // --------------------------------------------------------------------------
  // control and status
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      slot_reg       <= '0;
      rd_valid_reg   <= 1'b0;
      rd_data_reg    <= 8'h00;
      change_reg     <= 1'b0;
      hdlc_valid_reg <= 1'b0;
      hdlc_bits_reg  <= 2'h0;
    end else if (ce) begin
      rd_valid_reg   <= link.rd_req;
      rd_data_reg    <= cap_mem[link.rd_address];
      change_reg     <= beat && up_chg;
      hdlc_valid_reg <= beat && up_dch;
      if (beat) begin
        slot_reg <= cur + 1'b1;
        if (up_dch) begin
          hdlc_bits_reg <= link.sin_cfi[`TSS_DCH_LSB+1:`TSS_DCH_LSB];
        end
      end
    end
  end

  assign link.sin_ready = out_in_ready;
  assign link.rd_valid  = rd_valid_reg;
  assign link.rd_data   = rd_data_reg;
  assign change_irq     = change_reg;
  assign hdlc_up_valid  = hdlc_valid_reg;
  assign hdlc_up_bits   = hdlc_bits_reg;
endmodule // tss_switch

// File: rtl/tss_host.sv
// tss_host: processor-side end that programs the slot map and reads slots
// assumes: highway and subscriber streams are fed on the user side
`timescale 1ns/1ps
`include "tss_regs.svh"
module tss_host (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  tss_if.host             link,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic [1:0] cmd_kind,
  input  wire logic       cmd_dir,
  input  wire logic [6:0] cmd_slot,
  input  wire logic [6:0] cmd_spare,
  input  wire logic [3:0] cmd_code,
  input  wire logic [7:0] cmd_data,
  input  wire logic [1:0] cmd_pos,
  input  wire logic [1:0] cmd_width,
  input  wire logic       rd_req_in,
  input  wire logic [6:0] rd_slot,
  output logic            rd_valid_out,
  output logic [7:0]      rd_data_out,
  input  wire logic       usr_in_valid,
  output logic            usr_in_ready,
  input  wire logic       usr_in_frame,
  input  wire logic [7:0] usr_in_pcm,
  input  wire logic [7:0] usr_in_cfi,
  output logic            usr_out_valid,
  input  wire logic       usr_out_ready,
  output logic [7:0]      usr_out_cfi,
  output logic [7:0]      usr_out_pcm
);
  // --------------------------------------------------------------------------
  // command registers
  // --------------------------------------------------------------------------
  tss_pkg::tss_state_type state_reg;
  logic       map_wr_reg;
  logic       map_clear_reg;
  logic       map_dir_reg;
  logic [6:0] map_address_reg;
  logic [3:0] map_command_reg;
  logic [7:0] map_data_reg;
  logic [1:0] map_pos_reg;
  logic [1:0] map_width_reg;
  logic       s2_dir_reg;
  logic [6:0] s2_address_reg;
  logic [3:0] s2_command_reg;
  logic [7:0] s2_data_reg;
  logic [1:0] s2_pos_reg;
  logic       rd_req_reg;
  logic [6:0] rd_address_reg;
  logic       rd_valid_reg;
  logic [7:0] rd_data_reg;

  wire       take    = cmd_valid && cmd_ready;
  wire       is_pair = cmd_kind == `TSS_KIND_PAIR;
  wire       is_loop = cmd_kind == `TSS_KIND_LOOP;
  wire [6:0] even    = {cmd_slot[6:1], 1'b0};

  assign cmd_ready = ce && state_reg == tss_pkg::TSS_ST_IDLE;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg       <= tss_pkg::TSS_ST_IDLE;
      map_wr_reg      <= 1'b0;
      map_clear_reg   <= 1'b0;
      map_dir_reg     <= `TSS_DIR_UP;
      map_address_reg <= 7'h00;
      map_command_reg <= 4'h0;
      map_data_reg    <= 8'h00;
      map_pos_reg     <= 2'h0;
      map_width_reg   <= 2'h0;
      s2_dir_reg      <= `TSS_DIR_UP;
      s2_address_reg  <= 7'h00;
      s2_command_reg  <= 4'h0;
      s2_data_reg     <= 8'h00;
      s2_pos_reg      <= 2'h0;
    end else if (ce) begin
      map_wr_reg    <= 1'b0;
      map_clear_reg <= 1'b0;
      if (state_reg == tss_pkg::TSS_ST_SECOND) begin
        map_wr_reg      <= 1'b1;
        map_dir_reg     <= s2_dir_reg;
        map_address_reg <= s2_address_reg;
        map_command_reg <= s2_command_reg;
        map_data_reg    <= s2_data_reg;
        map_pos_reg     <= s2_pos_reg;
        state_reg       <= tss_pkg::TSS_ST_IDLE;
      end else if (take) begin
        map_clear_reg   <= cmd_kind == `TSS_KIND_CLEAR;
        map_wr_reg      <= cmd_kind != `TSS_KIND_CLEAR;
        map_dir_reg     <= is_loop ? `TSS_DIR_UP : cmd_dir;
        map_address_reg <= is_pair ? even : cmd_slot;
        map_command_reg <= is_loop ? 4'(tss_pkg::TSS_CODE_SW8) : cmd_code;
        map_data_reg    <= is_pair ? 8'h00 : is_loop ? {1'b0, cmd_spare} : cmd_data;
        map_pos_reg     <= is_pair ? `TSS_POS_EVEN : is_loop ? 2'h0 : cmd_pos;
        map_width_reg   <= cmd_width;
        s2_dir_reg      <= is_loop ? `TSS_DIR_DN : cmd_dir;
        s2_address_reg  <= is_pair ? (even | 7'h01) : cmd_data[6:0];
        s2_command_reg  <= is_loop ? 4'(tss_pkg::TSS_CODE_SW8) : cmd_code;
        s2_data_reg     <= is_loop ? {1'b0, cmd_spare} : cmd_data;
        s2_pos_reg      <= is_pair ? `TSS_POS_ODD : 2'h0;
        if (is_pair || is_loop) begin
          state_reg <= tss_pkg::TSS_ST_SECOND;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // slot readback
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_req_reg     <= 1'b0;
      rd_address_reg <= 7'h00;
      rd_valid_reg   <= 1'b0;
      rd_data_reg    <= 8'h00;
    end else if (ce) begin
      rd_req_reg     <= rd_req_in;
      rd_address_reg <= rd_slot;
      rd_valid_reg   <= link.rd_valid;
      rd_data_reg    <= link.rd_data;
    end
  end

  assign link.map_wr      = map_wr_reg;
  assign link.map_clear   = map_clear_reg;
  assign link.map_dir     = map_dir_reg;
  assign link.map_address = map_address_reg;
  assign link.map_command = map_command_reg;
  assign link.map_data    = map_data_reg;
  assign link.map_pos     = map_pos_reg;
  assign link.map_width   = map_width_reg;
  assign link.rd_req      = rd_req_reg;
  assign link.rd_address  = rd_address_reg;
  assign rd_valid_out     = rd_valid_reg;
  assign rd_data_out      = rd_data_reg;

  // stream passes straight through; the device end holds the buffer
  assign link.sin_valid   = usr_in_valid;
  assign link.sin_frame   = usr_in_frame;
  assign link.sin_pcm     = usr_in_pcm;
  assign link.sin_cfi     = usr_in_cfi;
  assign usr_in_ready     = link.sin_ready;
  assign usr_out_valid    = link.sout_valid;
  assign usr_out_cfi      = link.sout_cfi;
  assign usr_out_pcm      = link.sout_pcm;
  assign link.sout_ready  = usr_out_ready;
endmodule // tss_host

// File: tb/tss_monitor.sv
// tss_monitor: read and slot stream timing checks on the link
// assumes: instantiated beside the tss_if, ce held high
`timescale 1ns/1ps
module tss_monitor (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       rd_req,
  input wire logic       rd_valid,
  input wire logic       sin_valid,
  input wire logic       sin_ready,
  input wire logic       sout_valid,
  input wire logic       sout_ready,
  input wire logic [7:0] sout_cfi
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  rd_answer_a: assert property (rd_req |=> rd_valid)
    else $error("read not answered");
  rd_cause_a: assert property (rd_valid |-> $past(rd_req))
    else $error("read answer without request");
  out_hold_a: assert property (sout_valid && !sout_ready |=> sout_valid && $stable(sout_cfi))
    else $error("output changed while stalled");
  beat_out_a: assert property (sin_valid && sin_ready |=> sout_valid)
    else $error("accepted slot not presented");
  empty_ready_a: assert property (!sout_valid |-> sin_ready)
    else $error("empty buffer refuses");
  full_refuse_a: assert property (sout_valid && !sout_ready && sin_valid && sin_ready |=> !sin_ready)
    else $error("third slot accepted");
  rise_cause_a: assert property ($rose(sout_valid) |-> $past(sin_valid && sin_ready))
    else $error("output without input");
  fall_pop_a: assert property ($fell(sout_valid) |-> $past(sout_ready))
    else $error("output dropped unread");
endmodule // tss_monitor

// File: tb/tdm_slot_switch_map_test.sv
// tdm_slot_switch_map_test: host end and switch end joined, map and frame checks
// assumes: rtl package, interface and both ends compiled first
`timescale 1ns/1ps
module tdm_slot_switch_map_test;
  logic       sys_clk = 0, sys_rst = 1, ce = 1, stall = 0, dch_enable = 0, mon_rx_ready = 1, mon_tx_valid = 0;
  logic       cmd_valid = 0, cmd_dir = 0, rd_req_in = 0, usr_in_valid = 0, usr_in_frame = 0, usr_out_ready = 1;
  logic [1:0] cmd_kind = 0, cmd_pos = 0, cmd_width = 0, hdlc_dn_bits = 0, hdlc_up_bits;
  logic [6:0] cmd_slot = 0, cmd_spare = 0, rd_slot = 0, oc = 0;
  logic [3:0] cmd_code = 0;
  logic [7:0] cmd_data = 0, usr_in_pcm = 0, usr_in_cfi = 0, mon_tx_data = 0, v, mrx, hub;
  logic [7:0] rd_data_out, usr_out_cfi, usr_out_pcm, mon_rx_data, got_c [128], got_p [128];
  logic       cmd_ready, rd_valid_out, usr_in_ready, usr_out_valid, hdlc_up_valid, change_irq, mon_tx_ready, mon_rx_valid;
  int         err_count = 0, total_checks = 0, irqs = 0;
  // slot, flag for highway byte, expected value
  localparam logic [15:0] ROWS [11] = '{16'h00ff, 16'h035a, 16'h05fd, 16'h0bdf, 16'h0d7f,
                                        16'h0e42, 16'h0f3f, 16'h9407, 16'h9e57, 16'hb228, 16'h3ccd};
  tss_if tss_if_inst ();
  tss_host tss_host_inst (.sys_clk, .sys_rst, .ce, .link(tss_if_inst), .cmd_valid, .cmd_ready, .cmd_kind, .cmd_dir,
    .cmd_slot, .cmd_spare, .cmd_code, .cmd_data, .cmd_pos, .cmd_width, .rd_req_in, .rd_slot, .rd_valid_out,
    .rd_data_out, .usr_in_valid, .usr_in_ready, .usr_in_frame, .usr_in_pcm, .usr_in_cfi, .usr_out_valid,
    .usr_out_ready, .usr_out_cfi, .usr_out_pcm);
  tss_switch tss_switch_inst (.sys_clk, .sys_rst, .ce, .link(tss_if_inst), .dch_enable, .hdlc_dn_bits,
    .hdlc_up_valid, .hdlc_up_bits, .change_irq, .mon_tx_valid, .mon_tx_ready, .mon_tx_data, .mon_rx_valid,
    .mon_rx_ready, .mon_rx_data);
  tss_monitor tss_monitor_inst (.sys_clk, .sys_rst, .rd_req(tss_if_inst.rd_req), .rd_valid(tss_if_inst.rd_valid),
    .sin_valid(tss_if_inst.sin_valid), .sin_ready(tss_if_inst.sin_ready), .sout_valid(tss_if_inst.sout_valid),
    .sout_ready(tss_if_inst.sout_ready), .sout_cfi(tss_if_inst.sout_cfi));
  always #10 sys_clk = ~sys_clk;
  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  always @(posedge sys_clk) begin
    usr_out_ready <= stall ? ~usr_out_ready : 1'b1;
    if (change_irq === 1'b1) irqs++;
    if (mon_rx_valid === 1'b1) mrx = mon_rx_data;
    if (hdlc_up_valid === 1'b1) hub = {6'h0, hdlc_up_bits};
    if (usr_out_valid === 1'b1 && usr_out_ready) begin
      got_c[oc] = usr_out_cfi;
      got_p[oc] = usr_out_pcm;
      oc++;
    end
  end
  task automatic check(input string n, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmd(input logic [1:0] k, input logic d, input logic [6:0] s, input logic [3:0] c,
                     input logic [7:0] x, input logic [1:0] p, w);
    @(posedge sys_clk);
    {cmd_valid, cmd_kind, cmd_dir, cmd_slot, cmd_code, cmd_data, cmd_pos, cmd_width} <= {1'b1, k, d, s, c, x, p, w};
    #1;
    while (cmd_ready !== 1'b1) begin @(posedge sys_clk); #1; end
    @(posedge sys_clk);
    cmd_valid <= 0;
  endtask
  task automatic frame(input logic [7:0] k);
    @(posedge sys_clk);
    for (int s = 0; s < 128; s++) begin
      {usr_in_valid, usr_in_frame, usr_in_pcm, usr_in_cfi} <= {1'b1, s == 0, ~s[7:0], s[7:0] ^ k};
      #1;
      while (usr_in_ready !== 1'b1) begin @(posedge sys_clk); #1; end
      @(posedge sys_clk);
    end
    usr_in_valid <= 0;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [6:0] s, input logic [7:0] exp);
    @(posedge sys_clk);
    {rd_req_in, rd_slot} <= {1'b1, s};
    @(posedge sys_clk);
    rd_req_in <= 0;
    v = 8'h00;
    repeat (4) begin @(posedge sys_clk); if (rd_valid_out === 1'b1) v = rd_data_out; end
    check("rd_data", v, exp);
  endtask
  // -------------------------------------------------------------------------
  // sequence
  // -------------------------------------------------------------------------
  initial begin #200000; err_count++; test_done; end
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 0;
    #1 check("reset", {6'h0, usr_out_valid, rd_valid_out}, 8'h00);
    cmd(0, 1, 3, 4, 8'h5a, 0, 0);
    cmd(0, 1, 5, 1, 2, 0, 0);
    cmd(0, 1, 11, 2, 9, 1, 0);
    cmd(0, 1, 13, 3, 9, 1, 0);
    cmd(1, 1, 14, 7, 8'h3c, 0, 2);
    cmd(0, 0, 3, 4, 0, 0, 0);
    cmd(0, 0, 7, 1, 20, 0, 0);
    cmd(0, 0, 7'h71, 2, 30, 0, 0);
    cmd(0, 0, 7'h72, 3, 30, 2, 0);
    cmd(0, 0, 7'h73, 3, 30, 3, 0);
    cmd(1, 0, 16, 8, 0, 0, 0);
    cmd_spare <= 50;
    cmd(2, 0, 40, 0, 60, 0, 0);
    frame(0);
    @(posedge sys_clk) {mon_tx_valid, mon_tx_data, stall, irqs} <= {1'b1, 8'h42, 1'b1, 32'h0};
    @(posedge sys_clk) mon_tx_valid <= 0;
    frame(0);
    stall <= 0;
    foreach (ROWS[i]) check("slot", ROWS[i][15] ? got_p[ROWS[i][14:8]] : got_c[ROWS[i][14:8]], ROWS[i][7:0]);
    check("irqs", irqs[7:0], 0);
    check("mon_rx", mrx, 8'h10);
    rd(3, 8'h03);
    irqs = 0;
    {dch_enable, hdlc_dn_bits} <= 3'b110;
    frame(8'h80);
    check("irqs", irqs[7:0], 1);
    check("mon_rx", mrx, 8'h90);
    check("hdlc_up", hub, 8'h02);
    rd(3, 8'h83);
    cmd(3, 0, 0, 0, 0, 0, 0);
    cmd(1, 1, 14, 8, 8'h55, 0, 1);
    frame(0);
    check("cleared", got_c[3], 8'hff);
    check("pair", got_c[15], 8'h97);
    check("pair_even", got_c[14], 8'hff);
    test_done;
  end
endmodule // tdm_slot_switch_map_test
